// ---- bench/flow_totalizer_counter_tb_top.sv ----
/*
 * Self-checking bench: three totalizers, one per end-of-range mode, on shared stimulus.
 * Assumes tot_props is bound and host_model drives the panel and serial clear sources.
 */
`timescale 1ns/1ps
module flow_totalizer_counter_tb_top;
	import totalizer_pkg::*;
	// short tenth-hour so hours move within the run
	localparam logic [31:0] TICK = 32'h00000028;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic flow_valid_i = 1'b0;
	logic [23:0] flow_bcd_i = 24'h000000;
	logic panel_clear_i, rx_valid_i;
	logic [7:0] rx_byte_i;
	logic [23:0] tot_o [3];
	logic [15:0] hrs_o [3];
	logic [31:0] rdata [3];
	logic ovf [3];
	logic irq [3];
	logic [2:0] dp [3];
	int tot_m [3] = '{0, 0, 0};
	logic ovf_m = 1'b0;
	int errors = 0;
	int num_checks = 0;
	integer seed = 32'h1027;
	logic [63:0] q [$];
	logic [63:0] ent;
	logic rd_d = 1'b0;
	always #50 ref_clk_i = ~ref_clk_i;
	host_model host_u (.ref_clk_i(ref_clk_i), .panel_clear_o(panel_clear_i),
		.rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
	for (genvar m = 0; m < 3; m++) begin : g_mode
		flow_totalizer_counter #(.ROLL_MODE(roll_mode_t'(m)), .TICK_CYCLES(TICK)) dut_u (
			.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
			.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
			.reg_rdata_o(rdata[m]), .flow_valid_i(flow_valid_i), .flow_bcd_i(flow_bcd_i),
			.panel_clear_i(panel_clear_i), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
			.total_bcd_o(tot_o[m]), .hours_o(hrs_o[m]), .dp_pos_o(dp[m]),
			.overflow_err_o(ovf[m]), .irq_o(irq[m]));
	end
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [23:0] to_bcd(input int v);
		logic [23:0] b;
		for (int i = 0; i < 6; i++) begin
			b[4*i +: 4] = 4'(v % 10);
			v = v / 10;
		end
		return b;
	endfunction : to_bcd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i) reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk = '1);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		q.push_back({msk, exp});
		@(posedge ref_clk_i) reg_rd_i <= 1'b0;
	endtask : rd
	task automatic settle_chk();
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		for (int m = 0; m < 3; m++) begin
			chk({8'h00, tot_o[m]}, {8'h00, to_bcd(tot_m[m])});
		end
		chk({31'h0, ovf[2]}, {31'h0, ovf_m});
		chk({31'h0, ovf[1]}, 32'h0);
		chk({31'h0, ovf[0]}, 32'h0);
		chk({29'h0, dp[0]}, 32'h00000002);
	endtask : settle_chk
	// fixed below zero asks for random amounts; samples go back to back
	task automatic burst(input int n, input int fixed);
		int v, s;
		for (int i = 0; i < n; i++) begin
			v = (fixed >= 0) ? fixed : $unsigned($random(seed)) % 1000000;
			@(posedge ref_clk_i);
			flow_valid_i <= 1'b1;
			flow_bcd_i <= to_bcd(v);
			for (int m = 0; m < 3; m++) begin
				s = tot_m[m] + v;
				if (m == 2 && s > 999999) ovf_m = 1'b1;
				tot_m[m] = (m == 0) ? ((s > 999999) ? 999999 : s) : s % 1000000;
			end
		end
		@(posedge ref_clk_i) flow_valid_i <= 1'b0;
		settle_chk();
	endtask : burst
	task automatic do_clear(input int k);
		case (k)
			0: host_u.press();
			1: wr(8'h00, 32'h00004101);
			2: host_u.command(1'b0, 8'h00, 8'h54);
			default: begin
				wr(8'h00, 32'h00004202);
				rd(8'h00, 32'h00004202);
				host_u.command(1'b0, 8'h00, 8'h54);
				host_u.command(1'b1, 8'h41, 8'h54);
				settle_chk();
				host_u.command(1'b1, 8'h42, 8'h54);
			end
		endcase
		tot_m = '{0, 0, 0};
		ovf_m = 1'b0;
		settle_chk();
		chk({16'h0, hrs_o[0]}, 32'h0);
		rd(8'h04, 32'h00000004, 32'h00000004);
		wr(8'h04, 32'h00000004);
	endtask : do_clear
	// ****************************************************************
	// read scoreboard and sequence
	// ****************************************************************
	always @(posedge ref_clk_i) begin
		if (rd_d && q.size() > 0) begin
			ent = q.pop_front();
			chk(rdata[2] & ent[63:32], ent[31:0]);
		end
		rd_d <= reg_rd_i;
	end
	// the whole sequence needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		errors++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(8'h00, 32'h00004100);
		rd(8'h14, 32'h00000022);
		rd(8'h08, 32'h00000000);
		rd(8'h20, 32'h00000000);
		wr(8'h0C, 32'h00FFFFFF);
		rd(8'h0C, 32'h00000000);
		burst(1, 999998);
		burst(1, 1);
		burst(1, 5);
		rd(8'h0C, {8'h00, to_bcd(tot_m[2])});
		// wrap seen, no saturation and no clear yet in the notify instance
		rd(8'h04, 32'h00000001, 32'h00000007);
		for (int k = 0; k < 4; k++) begin
			burst(3, -1);
			do_clear(k);
		end
		wr(8'h00, 32'h00004100);
		burst(2, -1);
		host_u.command(1'b0, 8'h00, 8'h58);
		settle_chk();
		wr(8'h04, 32'h0000000F);
		wr(8'h08, 32'h00000004);
		host_u.press();
		tot_m = '{0, 0, 0};
		ovf_m = 1'b0;
		settle_chk();
		chk({31'h0, irq[2]}, 32'h1);
		wr(8'h04, 32'h00000004);
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk({31'h0, irq[2]}, 32'h0);
		wr(8'h08, 32'h00000000);
		host_u.press();
		settle_chk();
		chk({31'h0, irq[2]}, 32'h0);
		repeat (100) @(posedge ref_clk_i);
		rd(8'h10, 32'h00000002);
		// the last press and the tenth-hour ticks after it stay latched
		rd(8'h04, 32'h0000000C, 32'h0000000C);
		repeat (3) @(posedge ref_clk_i);
		end_sim();
	end
endmodule : flow_totalizer_counter_tb_top

// ---- bench/host_model.sv ----
/*
 * Front-panel clear button and serial host sending clear commands.
 * Assumes the receiver takes one byte per rx_valid_o cycle.
 */
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic ref_clk_i,
	// towards the totalizer
	output logic panel_clear_o,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o
);
	logic [7:0] byte_q = 8'h00;
	logic [7:0] noise_q = 8'h00;
	initial begin
		panel_clear_o = 1'b0;
		rx_valid_o = 1'b0;
	end
	// between bytes the line shows a running junk count instead of holding the last byte
	always @(posedge ref_clk_i) noise_q <= noise_q + 8'h35;
	assign rx_byte_o = rx_valid_o ? byte_q : noise_q;
	task automatic press();
		@(posedge ref_clk_i) panel_clear_o <= 1'b1;
		@(posedge ref_clk_i) panel_clear_o <= 1'b0;
	endtask : press
	task automatic send(input logic [7:0] b);
		@(posedge ref_clk_i);
		rx_valid_o <= 1'b1;
		byte_q <= b;
		@(posedge ref_clk_i) rx_valid_o <= 1'b0;
	endtask : send
	// cmd other than the letter T makes a broken command
	task automatic command(input logic poll, input logic [7:0] addr, input logic [7:0] cmd);
		if (poll) send(addr);
		send(8'h24);
		send(8'h24);
		send(cmd);
		send(8'h0D);
	endtask : command
endmodule : host_model

// ---- bench/tot_props.sv ----
/*
 * Checker for the flow totalizer top: clears, overflow flag, digit range, hours steps.
 * Assumes binding to every flow_totalizer_counter instance on its own ports.
 */
`timescale 1ns/1ps
module tot_props #(
	parameter logic [2:0] RES_DIGITS = 3'h2
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// clear sources and samples
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic flow_valid_i,
	input wire logic panel_clear_i,
	input wire logic rx_valid_i,
	// readings
	input wire logic [23:0] total_bcd_o,
	input wire logic [15:0] hours_o,
	input wire logic [2:0] dp_pos_o,
	input wire logic overflow_err_o
);
	logic maybe_clr;
	logic dig_ok;
	// any received byte might end a serial clear, so it counts as a possible clear
	assign maybe_clr = panel_clear_i | rx_valid_i |
		(reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[0]);
	always_comb begin
		dig_ok = 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (total_bcd_o[4*i +: 4] > 4'h9) begin
				dig_ok = 1'b0;
			end
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	// ****************************************************************
	// properties
	// ****************************************************************
	clear_zero_a: assert property (panel_clear_i |=>
		total_bcd_o == 24'h000000 && hours_o == 16'h0000)
		else $error("total or hours not zero after a clear");
	ovf_clear_a: assert property (panel_clear_i |=> !overflow_err_o)
		else $error("overflow flag survived a clear");
	ovf_hold_a: assert property (overflow_err_o && !maybe_clr |=> overflow_err_o)
		else $error("overflow flag dropped without a clear");
	idle_hold_a: assert property (!flow_valid_i && !maybe_clr |=> $stable(total_bcd_o))
		else $error("total moved without a sample");
	digit_range_a: assert property (dig_ok)
		else $error("total holds a non-decimal digit");
	dp_const_a: assert property (dp_pos_o == RES_DIGITS)
		else $error("decimal point differs from resolution");
	hours_step_a: assert property ($changed(hours_o) |->
		hours_o == $past(hours_o) + 16'h0001 || hours_o == 16'h0000)
		else $error("hours moved by other than one step");
	ovf_cause_a: assert property ($rose(overflow_err_o) |->
		$past(total_bcd_o) < $past(total_bcd_o, 2))
		else $error("overflow flag rose without a wrap");
	cover property (panel_clear_i);
	cover property ($rose(overflow_err_o));
	cover property ($changed(hours_o));
endmodule : tot_props

bind flow_totalizer_counter tot_props #(.RES_DIGITS(RES_DIGITS)) props_u (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .flow_valid_i(flow_valid_i), .panel_clear_i(panel_clear_i),
	.rx_valid_i(rx_valid_i), .total_bcd_o(total_bcd_o), .hours_o(hours_o),
	.dp_pos_o(dp_pos_o), .overflow_err_o(overflow_err_o)
);

// ---- rtl/bcd_accum.sv ----
/*
 * Six-digit decimal accumulator with selectable end-of-range handling.
 * Assumes sample amounts arrive as six BCD digits, one per valid cycle.
 */
`timescale 1ns/1ps
`include "totalizer_params.svh"
module bcd_accum
	import totalizer_pkg::*;
#(
	parameter totalizer_pkg::roll_mode_t MODE = totalizer_pkg::ROLL_NOTIFY
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// bundle
	tot_if.acc bus
);
	import totalizer_pkg::*;

	logic [`TOT_W-1:0] total_q, total_d;
	logic wrap_q, wrap_d;
	logic sat_q, sat_d;
	logic [`TOT_W-1:0] sum;
	logic [`TOT_DIGITS:0] carry;

	// ********************************************************************
	// digit chain
	// ********************************************************************
	assign carry[0] = 1'b0;
	for (genvar i = 0; i < `TOT_DIGITS; i++) begin : g_digit
		assign {carry[i+1], sum[4*i+3:4*i]} =
			bcd_digit_add(total_q[4*i+3:4*i], bus.smp_bcd[4*i+3:4*i], carry[i]); // [RULE_02]
	end

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		total_d = total_q;
		wrap_d = 1'b0;
		sat_d = sat_q;
		if (bus.clear) begin
			total_d = `TOT_ZERO; // [RULE_11] [RULE_13]
			sat_d = 1'b0;
		end else if (bus.smp_valid && !sat_q) begin // [RULE_05]
			if (MODE == ROLL_STOP && (carry[`TOT_DIGITS] || sum == `TOT_MAX)) begin // [RULE_04]
				total_d = `TOT_MAX; // [RULE_05]
				sat_d = 1'b1;
			end else begin
				// the carry out is dropped: the count restarts from zero
				total_d = sum; // [RULE_01] [RULE_06] [RULE_07] [RULE_13]
				wrap_d = carry[`TOT_DIGITS];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			total_q <= `TOT_ZERO;
			wrap_q <= 1'b0;
			sat_q <= 1'b0;
		end else begin
			total_q <= total_d;
			wrap_q <= wrap_d;
			sat_q <= sat_d;
		end
	end

	assign bus.total = total_q;
	assign bus.wrap_evt = wrap_q;
	assign bus.sat = sat_q;
endmodule : bcd_accum

// ---- rtl/flow_totalizer_counter.sv ----
/*
 * Flow totalizer top: register port, front-panel and serial clear,
 * overflow error, sticky status with mask and the interrupt line.
 * Assumes all inputs are synchronous to ref_clk_i and that the serial
 * receiver hands over one byte per rx_valid_i pulse.
 */
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "totalizer_params.svh"
module flow_totalizer_counter
	import totalizer_pkg::*;
#(
	parameter logic [2:0] RES_DIGITS = 3'h2,
	parameter totalizer_pkg::roll_mode_t ROLL_MODE = totalizer_pkg::ROLL_NOTIFY,
	parameter logic [31:0] TICK_CYCLES = 32'(`TENTH_HOUR_CYCLES)
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// flow samples
	input wire logic flow_valid_i,
	input wire logic [`TOT_W-1:0] flow_bcd_i,
	// front panel
	input wire logic panel_clear_i,
	// serial receiver bytes
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	// readings
	output logic [`TOT_W-1:0] total_bcd_o,
	output logic [`HRS_W-1:0] hours_o,
	output logic [2:0] dp_pos_o,
	output logic overflow_err_o,
	output logic irq_o
);
	import totalizer_pkg::*;

	tot_if tb_bus ();

	// ********************************************************************
	// counters
	// ********************************************************************
	bcd_accum #(
		.MODE(ROLL_MODE)
	) u_accum (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.bus(tb_bus.acc)
	);

	hour_meter #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_hours (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.bus(tb_bus.hrs)
	);

	// ********************************************************************
	// serial clear command parser
	// ********************************************************************
	parse_state_t pst_q, pst_d;
	logic poll_q, poll_d;
	logic [7:0] addr_q, addr_d;
	logic ser_clear;

	always_comb begin
		pst_d = pst_q;
		ser_clear = 1'b0;
		if (rx_valid_i) begin
			pst_d = ST_IDLE;
			unique case (pst_q)
				ST_IDLE: begin
					if (poll_q && rx_byte_i == addr_q) begin
						pst_d = ST_ADDR; // [RULE_12]
					end else if (!poll_q && rx_byte_i == `CH_DOLLAR) begin
						pst_d = ST_DOL1; // [RULE_12]
					end
				end
				ST_ADDR: begin
					if (rx_byte_i == `CH_DOLLAR) begin
						pst_d = ST_DOL1;
					end
				end
				ST_DOL1: begin
					if (rx_byte_i == `CH_DOLLAR) begin
						pst_d = ST_DOL2;
					end
				end
				ST_DOL2: begin
					if (rx_byte_i == `CH_T) begin
						pst_d = ST_CMD;
					end
				end
				ST_CMD: begin
					// only Enter completes the command
					ser_clear = (rx_byte_i == `CH_CR); // [RULE_12]
				end
				default: begin
					pst_d = ST_IDLE;
				end
			endcase
		end
	end

	// ********************************************************************
	// clear sources and samples
	// ********************************************************************
	logic reg_clear;
	logic clear_any;

	assign reg_clear = reg_wr_i && reg_addr_i == `REG_CTRL && reg_wdata_i[`CTRL_CLEAR];
	assign clear_any = panel_clear_i || ser_clear || reg_clear; // [RULE_10] [RULE_11]
	assign tb_bus.clear = clear_any;
	assign tb_bus.smp_valid = flow_valid_i; // [RULE_13]
	assign tb_bus.smp_bcd = flow_bcd_i;

	// ********************************************************************
	// overflow error, status, mask, interrupt
	// ********************************************************************
	logic ovf_q, ovf_d;
	logic sat_seen_q, sat_seen_d;
	logic [`ST_W-1:0] status_q, status_d;
	logic [`ST_W-1:0] mask_q, mask_d;
	logic [`ST_W-1:0] events;
	logic [`ST_W-1:0] w1c;
	logic irq_q, irq_d;

	always_comb begin
		events = `ST_ZERO;
		events[`ST_WRAP] = tb_bus.wrap_evt;
		events[`ST_SAT] = tb_bus.sat && !sat_seen_q;
		events[`ST_CLR] = clear_any;
		events[`ST_TICK] = tb_bus.tick_evt;
		w1c = `ST_ZERO;
		if (reg_wr_i && reg_addr_i == `REG_STATUS) begin
			w1c = reg_wdata_i[`ST_W-1:0];
		end
		// a new event outweighs a write-one-to-clear in the same cycle
		status_d = (status_q & ~w1c) | events;
		mask_d = mask_q;
		if (reg_wr_i && reg_addr_i == `REG_MASK) begin
			mask_d = reg_wdata_i[`ST_W-1:0];
		end
		irq_d = |(status_d & mask_d);
		sat_seen_d = tb_bus.sat;
		ovf_d = ovf_q;
		if (clear_any) begin
			ovf_d = 1'b0; // [RULE_14]
		end else if (tb_bus.wrap_evt && ROLL_MODE == ROLL_NOTIFY) begin
			ovf_d = 1'b1; // [RULE_07] [RULE_14]
		end
	end

	// ********************************************************************
	// register port
	// ********************************************************************
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] cfg_word;

	always_comb begin
		cfg_word = `RDATA_ZERO;
		cfg_word[`CFG_RES_MSB:`CFG_RES_LSB] = RES_DIGITS; // [RULE_03]
		cfg_word[`CFG_MODE_MSB:`CFG_MODE_LSB] = ROLL_MODE; // [RULE_04]
	end

	always_comb begin
		poll_d = poll_q;
		addr_d = addr_q;
		if (reg_wr_i && reg_addr_i == `REG_CTRL) begin
			poll_d = reg_wdata_i[`CTRL_POLL];
			addr_d = reg_wdata_i[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
		end
		rdata_d = `RDATA_ZERO;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`REG_CTRL: begin
					rdata_d[`CTRL_POLL] = poll_q;
					rdata_d[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB] = addr_q;
				end
				`REG_STATUS: begin
					rdata_d[`ST_W-1:0] = status_q;
				end
				`REG_MASK: begin
					rdata_d[`ST_W-1:0] = mask_q;
				end
				`REG_TOTAL: begin
					rdata_d[`TOT_W-1:0] = tb_bus.total;
				end
				`REG_HOURS: begin
					rdata_d[`HRS_W-1:0] = tb_bus.hours;
				end
				`REG_CONFIG: begin
					rdata_d = cfg_word;
				end
				default: begin
					rdata_d = `RDATA_ZERO;
				end
			endcase
		end
	end

	// ********************************************************************
	// state registers
	// ********************************************************************
	logic [2:0] dp_q;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pst_q <= ST_IDLE;
			poll_q <= 1'b0;
			addr_q <= `ADDR_RST;
			ovf_q <= 1'b0;
			sat_seen_q <= 1'b0;
			status_q <= `ST_ZERO;
			mask_q <= `ST_ZERO;
			irq_q <= 1'b0;
			rdata_q <= `RDATA_ZERO;
			dp_q <= RES_DIGITS;
		end else begin
			pst_q <= pst_d;
			poll_q <= poll_d;
			addr_q <= addr_d;
			ovf_q <= ovf_d;
			sat_seen_q <= sat_seen_d;
			status_q <= status_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
			dp_q <= RES_DIGITS;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	assign reg_rdata_o = rdata_q;
	assign total_bcd_o = tb_bus.total;
	assign hours_o = tb_bus.hours;
	// the count is always 0..999999; resolution only places the decimal point
	// held in a flop so that every output leaves the block registered
	assign dp_pos_o = dp_q; // [RULE_03]
	assign overflow_err_o = ovf_q;
	assign irq_o = irq_q;
endmodule : flow_totalizer_counter

// ---- rtl/hour_meter.sv ----
/*
 * Elapsed-hours meter in tenth-hour units with its own prescaler.
 * Assumes TICK_CYCLES clock cycles make one tenth of an hour.
 */
`timescale 1ns/1ps
`include "totalizer_params.svh"
module hour_meter #(
	parameter logic [31:0] TICK_CYCLES = 32'(`TENTH_HOUR_CYCLES)
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// bundle
	tot_if.hrs bus
);
	logic [31:0] presc_q, presc_d;
	logic [`HRS_W-1:0] hours_q, hours_d;
	logic tick_q, tick_d;

	always_comb begin
		presc_d = presc_q + `PRESC_ONE;
		hours_d = hours_q;
		tick_d = 1'b0;
		if (bus.clear) begin
			presc_d = `PRESC_ZERO; // [RULE_10]
			hours_d = `HRS_ZERO; // [RULE_10]
		end else if (presc_q >= TICK_CYCLES - `PRESC_ONE) begin
			presc_d = `PRESC_ZERO;
			tick_d = 1'b1; // [RULE_08]
			// stops at the top rather than wrapping back to a short time
			if (hours_q != `HRS_MAX) begin
				hours_d = hours_q + `HRS_W'(1); // [RULE_09]
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			presc_q <= `PRESC_ZERO;
			hours_q <= `HRS_ZERO; // [RULE_10]
			tick_q <= 1'b0;
		end else begin
			presc_q <= presc_d;
			hours_q <= hours_d;
			tick_q <= tick_d;
		end
	end

	assign bus.hours = hours_q;
	assign bus.tick_evt = tick_q;
endmodule : hour_meter

// ---- rtl/tot_if.sv ----
/*
 * Bundle between the totalizer control logic, the decimal accumulator
 * and the hours meter.
 * Assumes all three sit on one clock.
 */
`timescale 1ns/1ps
`include "totalizer_params.svh"
interface tot_if;
	logic clear;
	logic smp_valid;
	logic [`TOT_W-1:0] smp_bcd;
	logic [`TOT_W-1:0] total;
	logic wrap_evt;
	logic sat;
	logic tick_evt;
	logic [`HRS_W-1:0] hours;
	modport ctl(output clear, smp_valid, smp_bcd, input total, wrap_evt, sat, tick_evt, hours);
	modport acc(input clear, smp_valid, smp_bcd, output total, wrap_evt, sat);
	modport hrs(input clear, output tick_evt, hours);
endinterface : tot_if

// ---- rtl/totalizer_params.svh ----
/*
 * Constants of the flow totalizer: register map, field positions, reset
 * values, characters of the serial clear command and timing counts.
 * Assumes a 10 MHz system clock and a 32-bit register port.
 */
// Functional notes
// [RULE_01] Total accumulates flow since last clear, in main flow units.
// [RULE_02] Total is held in a six-digit decimal counter.
// [RULE_03] Resolution is fixed at configuration; maximum follows from it and six digits.
// [RULE_04] A fixed setting selects one of three end-of-range behaviours.
// [RULE_05] No-wrap: freeze at maximum, ignore flow until a clear.
// [RULE_06] Wrap: back to zero at maximum, keep counting, no indication. Code still sets the ST_WRAP status bit, which can raise irq_o.
// [RULE_07] Wrap with notify: back to zero, raise overflow error, keep counting.
// [RULE_08] Elapsed time since reset is counted in tenths of an hour.
// [RULE_09] Hours counter is sixteen bits of tenth-hour units, up to 6553.5 hours.
// [RULE_10] Hours reset on panel clear, serial clear and power loss.
// [RULE_11] Any clear request zeroes the total whatever the count or setting.
// [RULE_12] Host sends clear, address-prefixed when polling, ending with Enter.
// [RULE_13] One sample of flow added per period; clear beats the addition.
// [RULE_14] Overflow error holds until the next clear, then releases.
`ifndef TOTALIZER_PARAMS_SVH
`define TOTALIZER_PARAMS_SVH

// ********************************************************************
// counter geometry
// ********************************************************************
`define TOT_DIGITS 6
`define TOT_W 24
`define TOT_ZERO 24'h000000
`define TOT_MAX 24'h999999
`define DIGIT_MAX 5'h09
`define DIGIT_RADIX 5'h0A
`define HRS_W 16
`define HRS_ZERO 16'h0000
`define HRS_MAX 16'hFFFF

// ********************************************************************
// timing
// ********************************************************************
`define TENTH_HOUR_S 360
`define CLK_HZ 10000000
`define TENTH_HOUR_CYCLES (64'(`TENTH_HOUR_S) * 64'(`CLK_HZ))
`define PRESC_ZERO 32'h00000000
`define PRESC_ONE 32'h00000001

// ********************************************************************
// register map
// ********************************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_TOTAL 8'h0C
`define REG_HOURS 8'h10
`define REG_CONFIG 8'h14
`define RDATA_ZERO 32'h00000000
`define CTRL_CLEAR 0
`define CTRL_POLL 1
`define CTRL_ADDR_LSB 8
`define CTRL_ADDR_MSB 15
`define ADDR_RST 8'h41
`define ST_WRAP 0
`define ST_SAT 1
`define ST_CLR 2
`define ST_TICK 3
`define ST_W 4
`define ST_ZERO 4'h0
`define CFG_RES_LSB 0
`define CFG_RES_MSB 2
`define CFG_MODE_LSB 4
`define CFG_MODE_MSB 5

// ********************************************************************
// serial clear command characters
// ********************************************************************
`define CH_DOLLAR 8'h24
`define CH_T 8'h54
`define CH_CR 8'h0D

`endif

// ---- rtl/totalizer_pkg.sv ----
/*
 * Types shared by the totalizer modules: end-of-range mode, serial
 * parser states and the decimal digit adder.
 * Assumes totalizer_params.svh is on the include path.
 */
`include "totalizer_params.svh"
package totalizer_pkg;
	typedef enum logic [1:0] {ROLL_STOP, ROLL_WRAP, ROLL_NOTIFY} roll_mode_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DOL1, ST_DOL2, ST_CMD} parse_state_t;
	typedef logic [3:0] digit_t;

	// carry in bit 4, digit in bits 3:0
	function automatic logic [4:0] bcd_digit_add(input digit_t a, input digit_t b,
		input logic cin);
		logic [4:0] s;
		s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
		if (s > `DIGIT_MAX) begin
			s = {1'b1, 4'(s - `DIGIT_RADIX)};
		end
		return s;
	endfunction : bcd_digit_add
endpackage : totalizer_pkg
